// [msar_pkg.sv]
// Constants shared by the modem status and alarm report block.
// Assumes one system clock and an APB master with 32-bit data.
package msar_pkg;

    // ****************************************************
    // Register map (byte addresses)
    // ****************************************************
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  ADR_CTRL      = 8'h00;
    localparam logic [7:0]  ADR_LIVE      = 8'h04;
    localparam logic [7:0]  ADR_LATCH     = 8'h08;
    localparam logic [7:0]  ADR_DROP      = 8'h0C;
    localparam logic [7:0]  ADR_RPT_IDX   = 8'h10;
    localparam logic [7:0]  ADR_RPT_DATA  = 8'h14;

    // ****************************************************
    // Framing modes held in the control register
    // ****************************************************
    localparam logic [2:0]  FRM_T1_D4     = 3'h0;
    localparam logic [2:0]  FRM_T1_ESF    = 3'h1;
    localparam logic [2:0]  FRM_E1_FAS    = 3'h2;
    localparam logic [2:0]  FRM_E1_PCM30  = 3'h3;
    localparam logic [2:0]  FRM_E1_PCM30C = 3'h4;
    localparam int          CTRL_CRC_BIT  = 3;

    // ****************************************************
    // Control source codes
    // ****************************************************
    localparam logic [7:0]  SRC_PANEL     = 8'h00;
    localparam logic [7:0]  SRC_TERMINAL  = 8'h01;
    localparam logic [7:0]  SRC_COMPUTER  = 8'h02;

    // ****************************************************
    // Polarity and valid-bit masks of the alarm bytes
    // ****************************************************
    localparam logic [7:0]  TX_LOCK_MASK  = 8'h3C;
    localparam logic [5:0]  CLK_ACT_MASK  = 6'h0F;
    localparam logic [5:0]  COM1_MASK     = 6'h37;
    localparam logic [7:0]  BWD_MASK      = 8'h0F;

    // ****************************************************
    // Report byte positions
    // ****************************************************
    localparam logic [4:0]  RPT_MODE      = 5'h00;
    localparam logic [4:0]  RPT_TX        = 5'h01;
    localparam logic [4:0]  RPT_CLK       = 5'h02;
    localparam logic [4:0]  RPT_COM1      = 5'h03;
    localparam logic [4:0]  RPT_COM2      = 5'h04;
    localparam logic [4:0]  RPT_LTX       = 5'h05;
    localparam logic [4:0]  RPT_LCOM1     = 5'h06;
    localparam logic [4:0]  RPT_LCOM2     = 5'h07;
    localparam logic [4:0]  RPT_DROP      = 5'h08;
    localparam logic [4:0]  RPT_ONLINE    = 5'h09;
    localparam logic [4:0]  RPT_BWD       = 5'h0A;
    localparam logic [4:0]  RPT_MANT_HI   = 5'h0B;
    localparam logic [4:0]  RPT_MANT_LO   = 5'h0C;
    localparam logic [4:0]  RPT_EXP       = 5'h0D;
    localparam logic [4:0]  RPT_SYM3      = 5'h0F;
    localparam logic [4:0]  RPT_SYM2      = 5'h10;
    localparam logic [4:0]  RPT_SYM1      = 5'h11;
    localparam logic [4:0]  RPT_SYM0      = 5'h12;
    localparam logic [4:0]  RPT_LCLK      = 5'h13;
    localparam logic [4:0]  RPT_LDROP     = 5'h16;
    localparam logic [4:0]  RPT_LAST      = 5'h1A;

endpackage

// [msar_sync.sv]
// Two-stage synchroniser for a bundle of pin levels.
// Assumes each bit is a slow level; bits are not coherent to each other.
`timescale 1ns/10ps
module msar_sync
    import msar_pkg::*;
#(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_nxt;

    // Only the second stage is read outside this module.
    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= meta_nxt;
            sync_out <= sync_nxt;
        end
    end

endmodule

// [msar_sticky.sv]
// Sticky fault bits with write-one-to-clear.
// Assumes set and clear are single-cycle terms on the same clock.
`timescale 1ns/10ps
module msar_sticky
    import msar_pkg::*;
#(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Set by faults, cleared by software
    input  wire logic [W-1:0] set_in,
    input  wire logic [W-1:0] clr_in,
    output logic      [W-1:0] q_r
);

    logic [W-1:0] q_nxt;

    // A fault in the clearing cycle sets the bit again, so none is lost.
    always_comb begin
        q_nxt = (q_r & ~clr_in) | set_in;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

endmodule

// [msar_report.sv]
// Status and alarm report of a satellite modulator, read over APB.
// Assumes alarm pins are asynchronous levels and status words are on pclk.
`timescale 1ns/10ps
module msar_report
    import msar_pkg::*;
(
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Alarm pins
    input  wire logic [7:0]        tx_alarm_in,
    input  wire logic [5:0]        clk_alarm_in,
    input  wire logic [5:0]        com1_alarm_in,
    input  wire logic [2:0]        com2_alarm_in,
    input  wire logic [7:0]        drop_alarm_in,
    input  wire logic [3:0]        bwd_alarm_in,
    // Status words from modem logic
    input  wire logic [1:0]        ctrl_src_in,
    input  wire logic              online_in,
    input  wire logic [15:0]       ber_mant_in,
    input  wire logic [7:0]        ber_exp_in,
    input  wire logic [31:0]       sym_rate_in
);

    // ****************************************************
    // Pin synchronisers
    // ****************************************************
    logic [7:0] tx_s;
    logic [5:0] clk_s;
    logic [5:0] com1_s;
    logic [2:0] com2_s;
    logic [7:0] drop_s;
    logic [3:0] bwd_s;

    msar_sync #(.W(35)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({tx_alarm_in, clk_alarm_in, com1_alarm_in,
                    com2_alarm_in, drop_alarm_in, bwd_alarm_in}),
        .sync_out ({tx_s, clk_s, com1_s, com2_s, drop_s, bwd_s})
    );

    // ****************************************************
    // Control register
    // ****************************************************
    logic [2:0] frm_mode_r;
    logic [2:0] frm_mode_nxt;
    logic       crc_en_r;
    logic       crc_en_nxt;
    logic       wr_go;
    logic       rd_go;
    logic       setup;

    // A write lands only at the completing edge of the access phase.
    assign setup = psel & ~penable;
    assign wr_go = psel & penable & pready & pwrite;
    assign rd_go = psel & penable & pready & ~pwrite;

    always_comb begin
        frm_mode_nxt = frm_mode_r;
        crc_en_nxt   = crc_en_r;
        if (wr_go && paddr == ADR_CTRL) begin
            frm_mode_nxt = pwdata[2:0];
            crc_en_nxt   = pwdata[CTRL_CRC_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frm_mode_r <= FRM_T1_D4;
            crc_en_r   <= 1'b0;
        end else begin
            frm_mode_r <= frm_mode_nxt;
            crc_en_r   <= crc_en_nxt;
        end
    end

    // ****************************************************
    // Live bytes and framing validity
    // ****************************************************
    logic       is_e1;
    logic       mf_ok;
    logic       crc_ok;
    logic       fas;
    logic [7:0] tx_live;
    logic [7:0] clk_live;
    logic [7:0] com1_live;
    logic [7:0] com2_live;
    logic [7:0] drop_live;

    // Bits that mean nothing in the current framing read as zero.
    always_comb begin
        fas    = (frm_mode_r == FRM_E1_FAS);
        is_e1  = fas || frm_mode_r == FRM_E1_PCM30 || frm_mode_r == FRM_E1_PCM30C;
        mf_ok  = frm_mode_r == FRM_E1_PCM30 || frm_mode_r == FRM_E1_PCM30C;
        crc_ok = frm_mode_r == FRM_T1_ESF || (is_e1 && crc_en_r);
        tx_live   = tx_s;
        clk_live  = {2'b00, clk_s};
        com1_live = {2'b00, com1_s & COM1_MASK};
        com2_live = {5'b00000, com2_s};
        drop_live = {drop_s[7:6], drop_s[5] & ~fas, drop_s[4:3],
                     drop_s[2] & crc_ok, drop_s[1] & mf_ok, drop_s[0]};
    end

    // ****************************************************
    // Latched fault bytes
    // ****************************************************
    logic [7:0] tx_fail;
    logic [5:0] clk_fail;
    logic [5:0] com1_fail;
    logic [2:0] com2_fail;
    logic [7:0] lat_tx;
    logic [5:0] lat_clk;
    logic [5:0] lat_com1;
    logic [2:0] lat_com2;
    logic [2:0] lat_drop;
    logic [31:0] clr_lat;
    logic [2:0]  clr_drop;

    // Lock and activity bits are inverted so every latched bit means fail.
    always_comb begin
        tx_fail   = tx_live ^ TX_LOCK_MASK;
        clk_fail  = clk_s ^ CLK_ACT_MASK;
        com1_fail = com1_s & COM1_MASK;
        com2_fail = {~com2_s[2], ~com2_s[1], com2_s[0]};
        clr_lat   = (wr_go && paddr == ADR_LATCH) ? pwdata : 32'h0000_0000;
        clr_drop  = (wr_go && paddr == ADR_DROP) ? pwdata[10:8] : 3'h0;
    end

    msar_sticky #(.W(8)) u_lat_tx (
        .pclk    (pclk),
        .presetn (presetn),
        .set_in  (tx_fail),
        .clr_in  (clr_lat[7:0]),
        .q_r     (lat_tx)
    );

    msar_sticky #(.W(6)) u_lat_clk (
        .pclk    (pclk),
        .presetn (presetn),
        .set_in  (clk_fail),
        .clr_in  (clr_lat[13:8]),
        .q_r     (lat_clk)
    );

    msar_sticky #(.W(6)) u_lat_com1 (
        .pclk    (pclk),
        .presetn (presetn),
        .set_in  (com1_fail),
        .clr_in  (clr_lat[21:16]),
        .q_r     (lat_com1)
    );

    msar_sticky #(.W(3)) u_lat_com2 (
        .pclk    (pclk),
        .presetn (presetn),
        .set_in  (com2_fail),
        .clr_in  (clr_lat[26:24]),
        .q_r     (lat_com2)
    );

    // Only frame, multiframe and CRC lock faults are held.
    msar_sticky #(.W(3)) u_lat_drop (
        .pclk    (pclk),
        .presetn (presetn),
        .set_in  (drop_live[2:0]),
        .clr_in  (clr_drop),
        .q_r     (lat_drop)
    );

    // ****************************************************
    // Report byte stream
    // ****************************************************
    logic [4:0] rpt_idx_r;
    logic [4:0] rpt_idx_nxt;
    logic [7:0] rpt_byte;

    // Multi-byte fields go most significant byte first; gaps read zero.
    always_comb begin
        rpt_byte = 8'h00;
        unique case (rpt_idx_r)
            RPT_MODE:    rpt_byte = {6'h00, ctrl_src_in};
            RPT_TX:      rpt_byte = tx_live;
            RPT_CLK:     rpt_byte = clk_live;
            RPT_COM1:    rpt_byte = com1_live;
            RPT_COM2:    rpt_byte = com2_live;
            RPT_LTX:     rpt_byte = lat_tx;
            RPT_LCOM1:   rpt_byte = {2'b00, lat_com1};
            RPT_LCOM2:   rpt_byte = {5'h00, lat_com2};
            RPT_DROP:    rpt_byte = drop_live;
            RPT_ONLINE:  rpt_byte = {7'h00, online_in};
            RPT_BWD:     rpt_byte = {4'h0, bwd_s};
            RPT_MANT_HI: rpt_byte = ber_mant_in[15:8];
            RPT_MANT_LO: rpt_byte = ber_mant_in[7:0];
            RPT_EXP:     rpt_byte = ber_exp_in;
            RPT_SYM3:    rpt_byte = sym_rate_in[31:24];
            RPT_SYM2:    rpt_byte = sym_rate_in[23:16];
            RPT_SYM1:    rpt_byte = sym_rate_in[15:8];
            RPT_SYM0:    rpt_byte = sym_rate_in[7:0];
            RPT_LCLK:    rpt_byte = {2'b00, lat_clk};
            RPT_LDROP:   rpt_byte = {drop_live[7:3], lat_drop};
            default:     rpt_byte = 8'h00;
        endcase
    end

    // Reading the data port steps the index and wraps after the last byte.
    always_comb begin
        rpt_idx_nxt = rpt_idx_r;
        if (wr_go && paddr == ADR_RPT_IDX) begin
            rpt_idx_nxt = pwdata[4:0];
        end else if (rd_go && paddr == ADR_RPT_DATA) begin
            rpt_idx_nxt = (rpt_idx_r >= RPT_LAST) ? RPT_MODE : rpt_idx_r + 5'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rpt_idx_r <= RPT_MODE;
        end else begin
            rpt_idx_r <= rpt_idx_nxt;
        end
    end

    // ****************************************************
    // APB answer
    // ****************************************************
    logic [31:0] prdata_nxt;
    logic        pready_nxt;
    logic        pslverr_nxt;
    logic        hit;

    // Read data is captured in the setup cycle, so every access has one
    // wait-free access cycle; the latency is fixed at two edges.
    always_comb begin
        hit = paddr inside {ADR_CTRL, ADR_LIVE, ADR_LATCH, ADR_DROP,
                            ADR_RPT_IDX, ADR_RPT_DATA};
        pready_nxt  = setup;
        pslverr_nxt = setup & ~hit;
        prdata_nxt  = prdata;
        if (setup) begin
            prdata_nxt = 32'h0000_0000;
            if (!pwrite) begin
                unique case (paddr)
                    ADR_CTRL:     prdata_nxt = {28'h0, crc_en_r, frm_mode_r};
                    ADR_LIVE:     prdata_nxt = {com2_live, com1_live, clk_live, tx_live};
                    ADR_LATCH:    prdata_nxt = {5'h00, lat_com2, 2'b00, lat_com1,
                                                2'b00, lat_clk, lat_tx};
                    ADR_DROP:     prdata_nxt = {16'h0, drop_live[7:3], lat_drop, drop_live};
                    ADR_RPT_IDX:  prdata_nxt = {27'h0, rpt_idx_r};
                    ADR_RPT_DATA: prdata_nxt = {24'h0, rpt_byte};
                    default:      prdata_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= prdata_nxt;
            pready  <= pready_nxt;
            pslverr <= pslverr_nxt;
        end
    end

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_lat_tx_set: assert property (
        |tx_fail |=> ((lat_tx & $past(tx_fail)) == $past(tx_fail)))
        else $error("Transmit fault was not latched.");

    chk_lat_hold: assert property (
        ((($past(lat_tx) & ~$past(clr_lat[7:0])) & ~lat_tx) == 8'h00))
        else $error("Latched transmit bit dropped without a clear.");

    chk_lat_clk_set: assert property (
        (clk_s[0] == 1'b0) |=> lat_clk[0])
        else $error("Missing clock activity was not latched.");

    chk_lat_card: assert property (
        (com2_s[2] == 1'b0) |=> lat_com2[2])
        else $error("Absent IF card was not latched.");

    chk_lat_com1: assert property (
        com1_s[4] |=> lat_com1[4] && !lat_com1[3])
        else $error("Battery fault not latched or bit 3 set.");

    chk_mf_mask: assert property (
        (!mf_ok && !lat_drop[1] && clr_drop == 3'h0) |=> !lat_drop[1] || $past(mf_ok))
        else $error("Multiframe fault latched outside PCM30 framing.");

    chk_mfas_fas: assert property (
        fas |-> (drop_live[5] == 1'b0))
        else $error("MFAS alarm shown in FAS framing.");

    chk_ready_pulse: assert property (
        (psel && !penable) |=> pready ##1 !pready)
        else $error("Ready is not a single-cycle answer.");

    chk_sym_order: assert property (
        (setup && !pwrite && paddr == ADR_RPT_DATA && rpt_idx_r == RPT_SYM3)
        |=> (prdata[7:0] == $past(sym_rate_in[31:24])))
        else $error("Symbol rate not sent high byte first.");

    chk_bwd_spare: assert property (
        (rpt_idx_r == RPT_BWD) |-> (rpt_byte & ~BWD_MASK) == 8'h00)
        else $error("Backward alarm spare bits not zero.");

    chk_mode_code: assert property (
        (rpt_idx_r == RPT_MODE) |-> rpt_byte <= SRC_COMPUTER)
        else $error("Control source code out of range.");

    chk_ldrop_live: assert property (
        (rpt_idx_r == RPT_LDROP) |-> rpt_byte[7:3] == drop_live[7:3])
        else $error("Latched drop upper bits are not live.");

    cov_lat_clear: cover property (lat_tx[0] ##1 clr_lat[0] ##1 !lat_tx[0]);
    cov_set_wins:  cover property (clr_lat[1] && tx_fail[1]);
    cov_rpt_wrap:  cover property (rd_go && paddr == ADR_RPT_DATA && rpt_idx_r == RPT_LAST);
    cov_bad_addr:  cover property (pready && pslverr);

endmodule

// [msar_apb_master.sv]
// APB master model of the remote monitor-and-control computer.
// Assumes pclk comes from the bench and the slave ends each access with pready.
`timescale 1ns/10ps
module msar_apb_master
    import msar_pkg::*;
(
    // Clock
    input  wire logic              pclk,
    // Request
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic      [ADDR_W-1:0] paddr,
    output logic      [31:0]       pwdata,
    // Answer
    input  wire logic [31:0]       prdata,
    input  wire logic              pready,
    input  wire logic              pslverr,
    output logic                   hung
);
    // The bus is idle at time zero so no access is seen during reset.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
        hung = 1'b0;
    end

    // One transfer; the request holds until pready is sampled high.
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        // A slave that never answers is flagged rather than waited on forever.
        hung = (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// [testbench.sv]
// Self-checking bench of the status and alarm report block.
// Assumes the APB master model answers for the far side of the register bus.
`timescale 1ns/10ps
module testbench;
    import msar_pkg::*;
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel, penable, pwrite, pready, pslverr, hung;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd, sym = 32'h0, ex32;
    logic              err, onl = 1'b0;
    logic [7:0]        tx = 8'h3C, dr = 8'h0, ex = 8'h0;
    logic [5:0]        ck = 6'h0F, c1 = 6'h0;
    logic [2:0]        c2 = 3'h6;
    logic [3:0]        bw = 4'h0;
    logic [1:0]        src = 2'h0;
    logic [15:0]       mant = 16'h0;
    int                failures = 0, checks = 0, seed = 32'h8a0f0af3;

    msar_report i_msar_report (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_alarm_in(tx),
        .clk_alarm_in(ck), .com1_alarm_in(c1), .com2_alarm_in(c2), .drop_alarm_in(dr),
        .bwd_alarm_in(bw), .ctrl_src_in(src), .online_in(onl), .ber_mant_in(mant),
        .ber_exp_in(ex), .sym_rate_in(sym));
    msar_apb_master i_msar_apb_master (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hung(hung));

    // Free-running 250 MHz clock.
    always #2 pclk = ~pclk;

    // ****************************************
    // Checking and bus helpers
    // ****************************************
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // A hung access counts as a mismatch and ends the run at once.
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        i_msar_apb_master.xfer(w, a, d, rd, err);
        if (hung) begin
            failures++;
            tally_and_finish();
        end
    endtask

    // Healthy pins: loops locked, activity present, cards fitted.
    task automatic healthy();
        @(posedge pclk);
        tx <= 8'h3C;
        ck <= 6'h0F;
        c1 <= 6'h00;
        c2 <= 3'h6;
        dr <= 8'h00;
        repeat (5) @(posedge pclk);
    endtask

    function automatic logic [7:0] dmask(input logic [2:0] m, input logic c);
        dmask = 8'hFF;
        dmask[1] = (m == FRM_E1_PCM30) || (m == FRM_E1_PCM30C);
        dmask[2] = (m == FRM_T1_ESF) || (m >= FRM_E1_FAS && c);
        dmask[5] = (m != FRM_E1_FAS);
    endfunction

    function automatic logic [7:0] rpt(input int i);
        case (i)
            0: rpt = {6'h0, src};
            1: rpt = tx;
            2: rpt = {2'h0, ck};
            3: rpt = {2'h0, c1 & 6'h37};
            4: rpt = {5'h0, c2};
            9: rpt = {7'h0, onl};
            10: rpt = {4'h0, bw};
            11: rpt = mant[15:8];
            12: rpt = mant[7:0];
            5: rpt = tx ^ 8'h3C;
            6: rpt = {2'h0, c1 & 6'h37};
            7: rpt = {5'h0, c2 ^ 3'h6};
            8, 22: rpt = dr;
            13: rpt = ex;
            19: rpt = {2'h0, ck ^ 6'h0F};
            15, 16, 17, 18: rpt = sym[8*(18-i) +: 8];
            default: rpt = 8'h00;
        endcase
    endfunction

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        healthy();
        acc(1'b0, ADR_CTRL, 0);
        check(rd, 32'h0);
        // Lock faults seen while the synchronisers filled are cleared first.
        acc(1'b1, ADR_LATCH, 32'hFFFFFFFF);
        acc(1'b1, ADR_DROP, 32'h700);
        acc(1'b0, ADR_LATCH, 0);
        check(rd, 32'h0);
        // Random pins: live polarity, then latched faults after recovery.
        repeat (8) begin
            @(posedge pclk);
            tx <= 8'($random(seed));
            ck <= 6'($random(seed));
            c1 <= 6'($random(seed));
            c2 <= 3'($random(seed));
            repeat (5) @(posedge pclk);
            acc(1'b0, ADR_LIVE, 0);
            check(rd, {5'h0, c2, 2'h0, c1 & 6'h37, 2'h0, ck, tx});
            ex32 = {5'h0, c2 ^ 3'h6, 2'h0, c1 & 6'h37, 2'h0, ck ^ 6'h0F, tx ^ 8'h3C};
            // A clear while the faults still stand must leave them set.
            acc(1'b1, ADR_LATCH, 32'hFFFFFFFF);
            acc(1'b0, ADR_LATCH, 0);
            check(rd, ex32);
            healthy();
            acc(1'b0, ADR_LATCH, 0);
            check(rd, ex32);
            acc(1'b1, ADR_LATCH, 32'hFFFFFFFF);
            acc(1'b0, ADR_LATCH, 0);
            check(rd, 32'h0);
        end
        // Every framing mode with and without CRC: masking and drop latching.
        for (int m = 0; m < 5; m++) begin
            for (int c = 0; c < 2; c++) begin
                acc(1'b1, ADR_DROP, 32'h700);
                acc(1'b1, ADR_CTRL, 32'(m) | (32'(c) << CTRL_CRC_BIT));
                acc(1'b0, ADR_CTRL, 0);
                check(rd, 32'(m) | (32'(c) << CTRL_CRC_BIT));
                @(posedge pclk);
                dr <= 8'hFF;
                repeat (5) @(posedge pclk);
                acc(1'b0, ADR_DROP, 0);
                check(rd, {16'h0, dmask(3'(m), 1'(c)), dmask(3'(m), 1'(c))});
                healthy();
                acc(1'b0, ADR_DROP, 0);
                check(rd, {16'h0, dmask(3'(m), 1'(c)) & 8'h07, 8'h00});
            end
        end
        // Whole report read in index order with faults standing, wrapping after the last byte.
        acc(1'b1, ADR_DROP, 32'h700);
        @(posedge pclk);
        src <= 2'($unsigned($random(seed)) % 3);
        onl <= 1'($random(seed));
        bw <= 4'($random(seed));
        mant <= 16'($random(seed));
        ex <= 8'($random(seed));
        sym <= 32'($random(seed));
        tx <= 8'($random(seed));
        ck <= 6'($random(seed));
        c1 <= 6'($random(seed));
        c2 <= 3'($random(seed));
        dr <= 8'($random(seed));
        repeat (5) @(posedge pclk);
        acc(1'b1, ADR_RPT_IDX, 0);
        for (int i = 0; i < 28; i++) begin
            acc(1'b0, ADR_RPT_DATA, 0);
            check(rd, {24'h0, rpt(i % 27)});
        end
        // Unmapped address answers with an error and zero data.
        acc(1'b0, 8'h40, 0);
        check({rd[30:0], err}, 32'h1);
        tally_and_finish();
    end
endmodule
